// ===== hdl/dmace_regs.vh
// Register offsets, field positions, reset values and encodings of the DMA channel control block.
`ifndef DMACE_REGS_VH
`define DMACE_REGS_VH
`define DMACE_OFF_OPERATION 4'h0
`define DMACE_OFF_CHCR0 4'h1
`define DMACE_OFF_CHCR1 4'h2
`define DMACE_OFF_TCR0 4'h3
`define DMACE_OFF_TCR1 4'h4
`define DMACE_OFF_STATUS 4'h5
`define DMACE_BIT_CE 0
`define DMACE_BIT_TE 1
`define DMACE_BIT_IE 2
`define DMACE_BIT_TS_LO 3
`define DMACE_BIT_TS_HI 4
`define DMACE_BIT_RS_LO 8
`define DMACE_BIT_RS_HI 11
`define DMACE_BIT_ME 0
`define DMACE_BIT_NMI_FLAG 1
`define DMACE_BIT_AE 2
`define DMACE_RS_AUTO 4'h4
`define DMACE_RST_OPERATION 16'h0000
`define DMACE_RST_CHANNEL_CONTROL_REG 32'h00000000
`define DMACE_RST_TCR 24'h000000
`endif

// ===== hdl/dmace_channel.v
// One DMA channel: transfer-end flag, read-before-clear record, count and request handling.
`default_nettype none
`include "dmace_regs.vh"
module dmace_channel (
  input wire sys_clk,
  input wire arst_n,
  input wire standby,
  input wire global_ok,
  input wire [31:0] channel_control_reg_q,
  input wire tcr_wr,
  input wire [23:0] tcr_wdata,
  input wire channel_control_reg_rd,
  input wire channel_control_reg_wr,
  input wire te_wdata,
  input wire periph_req,
  input wire grant,
  input wire unit_done,
  output reg te_q,
  output reg [23:0] count_q,
  output wire want,
  output reg end_irq_q
);
  reg te_seen_q;
  reg pend_q;
  wire ce = channel_control_reg_q[`DMACE_BIT_CE];
  wire auto = channel_control_reg_q[`DMACE_BIT_RS_HI:`DMACE_BIT_RS_LO] == `DMACE_RS_AUTO;
  // Transfer allowed only with the channel enabled, flag clear and global conditions met.
  wire enabled = ce && !te_q && global_ok;
  wire last = count_q == 24'h000001;
  // Auto-request is always pending; peripheral requests are latched only after enable is set.
  assign want = enabled && (auto || pend_q);
  // Latch peripheral requests that arrive while enabled; drop them on any disable.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
    end else if (standby || !enabled || auto) begin
      pend_q <= 1'b0;
    end else if (periph_req) begin
      pend_q <= 1'b1;
    end else if (grant) begin
      pend_q <= 1'b0;
    end
  end
  // Count, transfer-end flag and its read record; the hardware set wins over a software clear.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 24'h000000;
      te_q <= 1'b0;
      te_seen_q <= 1'b0;
      end_irq_q <= 1'b0;
    end else if (standby) begin
      te_q <= 1'b0;
      te_seen_q <= 1'b0;
      end_irq_q <= 1'b0;
    end else begin
      end_irq_q <= 1'b0;
      if (tcr_wr) begin
        count_q <= tcr_wdata;
      end else if (unit_done && enabled) begin
        count_q <= count_q - 24'h000001;
      end
      if (unit_done && enabled && last) begin
        te_q <= 1'b1;
        te_seen_q <= 1'b0;
        end_irq_q <= channel_control_reg_q[`DMACE_BIT_IE];
      end else if (channel_control_reg_wr && !te_wdata && te_seen_q) begin
        te_q <= 1'b0;
        te_seen_q <= 1'b0;
      end else if (channel_control_reg_rd && te_q) begin
        te_seen_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/dmace_top.v
// Top of the DMA channel-enable and termination block with its Avalon-MM register slave.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`default_nettype none
`include "dmace_regs.vh"
module dmace_top (
  input wire sys_clk,
  input wire arst_n,
  input wire standby,
  input wire nmi,
  input wire [1:0] periph_req,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] bus_req_q,
  output reg [1:0] bus_size_q,
  input wire bus_done,
  input wire bus_addr_err,
  output reg [1:0] end_irq_q
);
  reg [15:0] oper_q;
  reg ae_seen_q;
  reg nmi_flag_seen_q;
  reg [31:0] chcr0_q;
  reg [31:0] chcr1_q;
  reg [1:0] busy_ch_q;
  reg [31:0] rd_d;
  wire [1:0] te;
  wire [1:0] want;
  wire [1:0] irq;
  wire [23:0] cnt0;
  wire [23:0] cnt1;
  wire acc = (avs_read || avs_write) && avs_waitrequest;
  wire rd = avs_read && avs_waitrequest;
  // A write lands only at the edge at which the master sees waitrequest low.
  wire wr = avs_write && !avs_waitrequest;
  wire sel_op = avs_address == `DMACE_OFF_OPERATION;
  wire sel_c0 = avs_address == `DMACE_OFF_CHCR0;
  wire sel_c1 = avs_address == `DMACE_OFF_CHCR1;
  // Global enable: master enable set and neither abort flag raised.
  wire global_ok = oper_q[`DMACE_BIT_ME] && !oper_q[`DMACE_BIT_NMI_FLAG] && !oper_q[`DMACE_BIT_AE];
  wire [1:0] done = {bus_done && busy_ch_q[1] && !bus_addr_err, bus_done && busy_ch_q[0] && !bus_addr_err};
  // Grants as the arbiter takes them: channel 0 first, channel 1 only when channel 0 does not want.
  wire grant0 = busy_ch_q == 2'b00 && want[0];
  wire grant1 = busy_ch_q == 2'b00 && !want[0] && want[1];
  // Each cycle of a request is answered one cycle later: waitrequest drops for exactly one edge.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= !(acc);
      if (rd) begin
        avs_readdata <= rd_d;
      end
    end
  end
  // Read data mux with unmapped offsets reading zero.
  always @* begin
    if (sel_op) begin
      rd_d = {16'h0000, 13'h0000, oper_q[2:0]};
    end else if (sel_c0) begin
      rd_d = {chcr0_q[31:2], te[0], chcr0_q[0]};
    end else if (sel_c1) begin
      rd_d = {chcr1_q[31:2], te[1], chcr1_q[0]};
    end else if (avs_address == `DMACE_OFF_TCR0) begin
      rd_d = {8'h00, cnt0};
    end else if (avs_address == `DMACE_OFF_TCR1) begin
      rd_d = {8'h00, cnt1};
    end else if (avs_address == `DMACE_OFF_STATUS) begin
      rd_d = {28'h0000000, busy_ch_q, want};
    end else begin
      rd_d = 32'h00000000;
    end
  end
  // Operation register: hardware sets of NMI and address error beat software clears.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oper_q <= `DMACE_RST_OPERATION;
      ae_seen_q <= 1'b0;
      nmi_flag_seen_q <= 1'b0;
    end else if (standby) begin
      oper_q <= `DMACE_RST_OPERATION;
      ae_seen_q <= 1'b0;
      nmi_flag_seen_q <= 1'b0;
    end else begin
      if (wr && sel_op) begin
        oper_q[`DMACE_BIT_ME] <= avs_writedata[`DMACE_BIT_ME];
      end
      if (bus_addr_err && busy_ch_q != 2'b00) begin
        oper_q[`DMACE_BIT_AE] <= 1'b1;
        ae_seen_q <= 1'b0;
      end else if (wr && sel_op && !avs_writedata[`DMACE_BIT_AE] && ae_seen_q) begin
        oper_q[`DMACE_BIT_AE] <= 1'b0;
        ae_seen_q <= 1'b0;
      end else if (rd && sel_op && oper_q[`DMACE_BIT_AE]) begin
        ae_seen_q <= 1'b1;
      end
      if (nmi) begin
        oper_q[`DMACE_BIT_NMI_FLAG] <= 1'b1;
        nmi_flag_seen_q <= 1'b0;
      end else if (wr && sel_op && !avs_writedata[`DMACE_BIT_NMI_FLAG] && nmi_flag_seen_q) begin
        oper_q[`DMACE_BIT_NMI_FLAG] <= 1'b0;
        nmi_flag_seen_q <= 1'b0;
      end else if (rd && sel_op && oper_q[`DMACE_BIT_NMI_FLAG]) begin
        nmi_flag_seen_q <= 1'b1;
      end
    end
  end
  // Channel control registers; the flag bit of a control write goes to the channel, which also keeps the count.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chcr0_q <= `DMACE_RST_CHANNEL_CONTROL_REG;
      chcr1_q <= `DMACE_RST_CHANNEL_CONTROL_REG;
    end else if (standby) begin
      chcr0_q <= `DMACE_RST_CHANNEL_CONTROL_REG;
      chcr1_q <= `DMACE_RST_CHANNEL_CONTROL_REG;
    end else if (wr) begin
      if (sel_c0) begin
        chcr0_q <= {avs_writedata[31:2], 1'b0, avs_writedata[0]};
      end else if (sel_c1) begin
        chcr1_q <= {avs_writedata[31:2], 1'b0, avs_writedata[0]};
      end
    end
  end
  // Arbiter: one unit in flight; channel 0 wins; an abort drops the unit in progress.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ch_q <= 2'b00;
      bus_req_q <= 2'b00;
      bus_size_q <= 2'b00;
      end_irq_q <= 2'b00;
    end else begin
      end_irq_q <= irq;
      if (standby || !global_ok || bus_done || bus_addr_err ||
          (busy_ch_q[0] && !want[0] && !chcr0_q[`DMACE_BIT_CE]) ||
          (busy_ch_q[1] && !want[1] && !chcr1_q[`DMACE_BIT_CE])) begin
        busy_ch_q <= 2'b00;
        bus_req_q <= 2'b00;
      end else if (busy_ch_q == 2'b00 && want[0]) begin
        busy_ch_q <= 2'b01;
        bus_req_q <= 2'b01;
        bus_size_q <= chcr0_q[`DMACE_BIT_TS_HI:`DMACE_BIT_TS_LO];
      end else if (busy_ch_q == 2'b00 && want[1]) begin
        busy_ch_q <= 2'b10;
        bus_req_q <= 2'b10;
        bus_size_q <= chcr1_q[`DMACE_BIT_TS_HI:`DMACE_BIT_TS_LO];
      end
    end
  end
  // Channel 0: flag, count and request handling.
  dmace_channel u_ch0 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .standby(standby),
    .global_ok(global_ok),
    .channel_control_reg_q(chcr0_q),
    .tcr_wr(wr && avs_address == `DMACE_OFF_TCR0),
    .tcr_wdata(avs_writedata[23:0]),
    .channel_control_reg_rd(rd && sel_c0),
    .channel_control_reg_wr(wr && sel_c0),
    .te_wdata(avs_writedata[`DMACE_BIT_TE]),
    .periph_req(periph_req[0]),
    .grant(grant0),
    .unit_done(done[0]),
    .te_q(te[0]),
    .count_q(cnt0),
    .want(want[0]),
    .end_irq_q(irq[0])
  );
  // Channel 1: same logic, served only when channel 0 does not want the bus.
  dmace_channel u_ch1 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .standby(standby),
    .global_ok(global_ok),
    .channel_control_reg_q(chcr1_q),
    .tcr_wr(wr && avs_address == `DMACE_OFF_TCR1),
    .tcr_wdata(avs_writedata[23:0]),
    .channel_control_reg_rd(rd && sel_c1),
    .channel_control_reg_wr(wr && sel_c1),
    .te_wdata(avs_writedata[`DMACE_BIT_TE]),
    .periph_req(periph_req[1]),
    .grant(grant1),
    .unit_done(done[1]),
    .te_q(te[1]),
    .count_q(cnt1),
    .want(want[1]),
    .end_irq_q(irq[1])
  );
endmodule
`default_nettype wire

// ===== sim/dmace_top_assertions.sv
// Concurrent checks on the ports of the DMA channel block.
`default_nettype none
module dmace_top_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic nmi,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] bus_req_q,
  input wire logic bus_done,
  input wire logic bus_addr_err,
  input wire logic [1:0] end_irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  reserved_zero_a: assert property (
    !avs_waitrequest && avs_read && avs_address == 4'h0 |-> avs_readdata[15:3] == 13'h0000)
    else $error("reserved operation bits read nonzero");
  answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  req_onehot_a: assert property ($onehot0(bus_req_q))
    else $error("two channels served at once");
  req_hold_a: assert property (
    bus_req_q != 2'b00 && !bus_done && !bus_addr_err && !nmi && !$past(nmi) && !avs_write && !$past(avs_write)
      |=> $stable(bus_req_q))
    else $error("unit request dropped early");
  irq_pulse_a: assert property (end_irq_q[0] |=> !end_irq_q[0])
    else $error("end interrupt longer than one cycle");
  irq_cause_a: assert property ($rose(end_irq_q[0]) |-> $past(bus_done, 2))
    else $error("end interrupt without final unit");
  err_stop_a: assert property (bus_addr_err |=> (bus_req_q == 2'b00) [*3])
    else $error("transfer after address error");
  nmi_halt_a: assert property ($past(nmi) && bus_req_q == 2'b00 |-> (bus_req_q == 2'b00) [*3])
    else $error("transfer after nmi");
endmodule
bind dmace_top dmace_top_assertions chk (.sys_clk(sys_clk), .arst_n(arst_n), .nmi(nmi),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .bus_req_q(bus_req_q), .bus_done(bus_done),
  .bus_addr_err(bus_addr_err), .end_irq_q(end_irq_q));
`default_nettype wire

// ===== sim/dmace_bus_model.sv
// Bus-side partner that answers each unit after a set delay.
`default_nettype none
module dmace_bus_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [1:0] bus_req_q,
  input wire logic [2:0] delay,
  input wire logic fault,
  output logic bus_done,
  output logic bus_addr_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  // Counts cycles of a held unit, then ends it with one pulse.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 3'h0;
      bus_done <= 1'b0;
      bus_addr_err <= 1'b0;
    end else if (bus_req_q != 2'b00 && !bus_done && !bus_addr_err && wait_q == delay) begin
      wait_q <= 3'h0;
      bus_done <= !fault;
      bus_addr_err <= fault;
    end else begin
      wait_q <= (bus_req_q != 2'b00 && !bus_done && !bus_addr_err) ? wait_q + 3'h1 : 3'h0;
      bus_done <= 1'b0;
      bus_addr_err <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/dmace_top_tb.sv
// Self-checking bench for the DMA channel block.
`default_nettype none
module dmace_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, standby, nmi, avs_read, avs_write, avs_waitrequest, bus_done, bus_addr_err, fault;
  logic [1:0] periph_req, bus_req_q, bus_size_q, end_irq_q, irq_seen;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int n_mismatch, checks_done;
  dmace_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .standby(standby), .nmi(nmi), .periph_req(periph_req),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_req_q(bus_req_q),
    .bus_size_q(bus_size_q), .bus_done(bus_done), .bus_addr_err(bus_addr_err), .end_irq_q(end_irq_q));
  dmace_bus_model partner (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req_q(bus_req_q), .delay(3'h2),
    .fault(fault), .bus_done(bus_done), .bus_addr_err(bus_addr_err));
  // Clock, and a record of every end interrupt seen.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) irq_seen <= arst_n ? (irq_seen | end_irq_q) : 2'b00;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic bus_rd(input logic [3:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset values and an unmapped address.
  task automatic t_reset;
    bus_rd(4'h0); check(rd, 32'h0);
    bus_rd(4'h1); check(rd, 32'h0);
    bus_rd(4'hF); check(rd, 32'h0);
  endtask
  // Both channels on auto-request, end flags and the read-before-clear of channel 1's flag.
  task automatic t_run;
    bus_wr(4'h3, 32'h3);
    bus_wr(4'h4, 32'h1);
    bus_wr(4'h1, 32'h415);
    bus_wr(4'h2, 32'h40D);
    bus_wr(4'h0, 32'h1);
    for (int i = 0; i < 50 && bus_req_q == 2'b00; i++) @(posedge sys_clk);
    check({30'h0, bus_req_q}, 32'h1);
    check({30'h0, bus_size_q}, 32'h2);
    for (int i = 0; i < 100 && bus_req_q != 2'b10; i++) @(posedge sys_clk);
    check({30'h0, bus_size_q}, 32'h1);
    for (int i = 0; i < 200 && irq_seen != 2'b11; i++) @(posedge sys_clk);
    check({30'h0, irq_seen}, 32'h3);
    bus_rd(4'h3); check(rd, 32'h0);
    bus_rd(4'h1); check(rd, 32'h417);
    bus_wr(4'h2, 32'h404);
    bus_rd(4'h2); check(rd, 32'h406);
    bus_wr(4'h2, 32'h404);
    bus_rd(4'h2); check(rd, 32'h404);
    bus_wr(4'h3, 32'h3);
    repeat (20) @(posedge sys_clk);
    check({30'h0, bus_req_q}, 32'h0);
    bus_rd(4'h3); check(rd, 32'h3);
  endtask
  // Peripheral-request mode waits for a request that arrives after enable.
  task automatic t_periph;
    bus_wr(4'h4, 32'h1);
    bus_wr(4'h2, 32'h5);
    repeat (20) @(posedge sys_clk);
    check({30'h0, bus_req_q}, 32'h0);
    periph_req <= 2'b10;
    @(posedge sys_clk);
    periph_req <= 2'b00;
    repeat (20) @(posedge sys_clk);
    bus_rd(4'h2); check(rd, 32'h7);
    bus_wr(4'h2, 32'h0);
    bus_rd(4'h2); check(rd, 32'h0);
  endtask
  // NMI flag set, refused set and clear after read.
  task automatic t_nmi;
    nmi <= 1'b1;
    @(posedge sys_clk);
    nmi <= 1'b0;
    @(posedge sys_clk);
    bus_rd(4'h0); check(rd, 32'h3);
    bus_wr(4'h0, 32'hFFFE);
    bus_rd(4'h0); check(rd, 32'h2);
    bus_wr(4'h0, 32'h1);
    bus_wr(4'h0, 32'h7);
    bus_rd(4'h0); check(rd, 32'h1);
  endtask
  // Address error mid-count, then standby.
  task automatic t_fault;
    fault <= 1'b1;
    bus_wr(4'h4, 32'h2);
    bus_wr(4'h2, 32'h405);
    for (int i = 0; i < 50 && !bus_addr_err; i++) @(posedge sys_clk);
    @(posedge sys_clk);
    bus_rd(4'h0); check(rd, 32'h5);
    bus_rd(4'h2); check(rd, 32'h405);
    bus_rd(4'h4); check(rd, 32'h2);
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    bus_rd(4'h0); check(rd, 32'h0);
  endtask
  // Main sequence.
  initial begin
    {arst_n, standby, nmi, avs_read, avs_write, fault} = 6'h00;
    {periph_req, avs_address, avs_writedata} = 38'h0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_run();
    t_periph();
    t_nmi();
    t_fault();
    give_verdict();
  end
  // Watchdog.
  initial begin
    #100us;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
